// file: rtl/ccr_regs.sv
// Purpose: front configuration registers of a tft controller behind apb
// Assumes: pins from outside are synchronised here; apb is on pclk
// Notes: index n sits at byte address 4*n; unmapped addresses give pslverr
//
// Contract
// - writing one to reset register bit 7 applies staged pll parameters
// - pll reconfigure bit reads back, high until switch-over done
// - writing one to bit 0 starts soft reset; bit self-clears when done
// - soft reset restarts state machines, keeps config, restores the warning flag; pll ready is kept
// - warning flag reads one after a warning occurred, else zero
// - pll ready bit reads one once pll switched successfully
// - bit 6 set masks stall on chip select release; clear keeps stall
// - tft width field picks 24, 18, 16 or none; reset 01b
// - bit 2 i2c, bit 5 keypad; both give key line 0 to i2c
// - bit 1 hands serial flash pins to spi master
// - bus width bit forced zero for serial host or initial display
// - image format 0x direct, 10b mask every high byte, 11b even only
// - read direction field sets scan order, ignored in linear mode
// - write direction field sets write order, ignored in linear mode
`timescale 1ns/1ps
`include "ccr_consts.svh"
module ccr_regs (
	// clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// apb slave
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [11:0]   paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	// host side pins and status
	input  wire logic          host_cs_n,
	input  wire logic          serial_host_sel,
	input  wire logic          init_display,
	input  wire logic          core_busy,
	input  wire logic          warning_event,
	input  wire logic          canvas_linear,
	output logic               host_wait_n,
	// configuration outputs
	output logic [7:0]         pll_param_stage,
	input  wire logic [7:0]    pll_param_in,
	output logic [7:0]         pll_param_live,
	output logic               soft_reset_active,
	output logic               host_bus_16,
	output ccr_pkg::ccr_pinmux_t pinmux,
	output ccr_pkg::ccr_access_t access_ctl,
	// interrupt
	output logic               irq
);
	// synchronisers
	logic [1:0] cs_s_q, ser_s_q, init_s_q, busy_s_q, warn_s_q, lin_s_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cs_s_q   <= 2'h3;
			ser_s_q  <= 2'h0;
			init_s_q <= 2'h0;
			busy_s_q <= 2'h0;
			warn_s_q <= 2'h0;
			lin_s_q  <= 2'h0;
		end else begin
			cs_s_q   <= {cs_s_q[0], host_cs_n};
			ser_s_q  <= {ser_s_q[0], serial_host_sel};
			init_s_q <= {init_s_q[0], init_display};
			busy_s_q <= {busy_s_q[0], core_busy};
			warn_s_q <= {warn_s_q[0], warning_event};
			lin_s_q  <= {lin_s_q[0], canvas_linear};
		end
	end

	// apb decode
	logic       acc, wr, rd;
	logic [9:0] idx;
	logic       mapped;
	assign acc    = psel & penable;
	assign idx    = paddr[11:2];
	assign mapped = (paddr[1:0] == 2'h0) && (idx <= 10'(`CCR_IDX_IRQ_MASK));
	assign wr     = acc & pwrite & mapped;
	assign rd     = acc & ~pwrite & mapped;

	function automatic logic hit(input logic [9:0] i, input logic [7:0] n);
		hit = (i == {2'h0, n});
	endfunction

	logic w_srr, w_cfg, w_mac, w_ist, w_imk;
	assign w_srr = wr & hit(idx, `CCR_IDX_SRR);
	assign w_cfg = wr & hit(idx, `CCR_IDX_CFG);
	assign w_mac = wr & hit(idx, `CCR_IDX_MAC);
	assign w_ist = wr & hit(idx, `CCR_IDX_IRQ_STAT);
	assign w_imk = wr & hit(idx, `CCR_IDX_IRQ_MASK);

	// sequencers
	logic srst_start, srst_busy, srst_done;
	logic pll_start, pll_busy, pll_done;
	// the done cycle is not idle yet: a start there would be lost and the bit stuck
	assign srst_start = w_srr & pwdata[`CCR_SRR_SRST_BIT] & ~srst_busy & ~srst_done;
	assign pll_start  = w_srr & pwdata[`CCR_SRR_PLL_BIT] & ~pll_busy & ~pll_done;

	ccr_seq #(.CYCLES(`CCR_SRST_CYC)) u_srst (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (srst_start),
		.busy    (srst_busy),
		.done    (srst_done)
	);

	ccr_seq #(.CYCLES(`CCR_PLL_CYC)) u_pll (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (pll_start),
		.busy    (pll_busy),
		.done    (pll_done)
	);

	// reset register state
	logic srst_bit_q, pll_bit_q, warn_q, pll_rdy_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			srst_bit_q <= 1'b0;
		end else if (srst_start) begin
			srst_bit_q <= 1'b1;
		end else if (srst_done) begin
			srst_bit_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_bit_q <= 1'b0;
		end else if (pll_start) begin
			pll_bit_q <= 1'b1;
		end else if (pll_done) begin
			pll_bit_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_rdy_q <= 1'b0;
		end else if (pll_start) begin
			pll_rdy_q <= 1'b0;
		end else if (pll_done) begin
			pll_rdy_q <= 1'b1;
		end
	end

	// the soft reset restores the flag even if a warning arrives meanwhile
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			warn_q <= 1'b0;
		end else if (srst_busy) begin
			warn_q <= 1'b0;
		end else if (warn_s_q[1]) begin
			warn_q <= 1'b1;
		end
	end

	// pll parameters only reach the live copy on a reconfigure
	logic [7:0] pll_live_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_live_q <= 8'h00;
		end else if (pll_done) begin
			pll_live_q <= pll_param_in;
		end
	end
	// staged copy is registered so the pin comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_param_stage <= 8'h00;
		end else begin
			pll_param_stage <= pll_param_in;
		end
	end
	assign pll_param_live  = pll_live_q;

	// configuration registers survive soft reset
	logic [7:0] cfg_q, mac_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= `CCR_CFG_RESET;
		end else if (w_cfg) begin
			cfg_q <= {1'b0, pwdata[6:0]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mac_q <= `CCR_MAC_RESET;
		end else if (w_mac) begin
			mac_q <= pwdata[7:0] & `CCR_MAC_WMASK;
		end
	end

	// interrupts: set wins over write-one-to-clear
	logic [2:0] ist_q, imk_q, ev;
	assign ev = {warn_s_q[1] & ~warn_q, srst_done, pll_done};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ist_q <= 3'h0;
		end else begin
			ist_q <= (ist_q & ~({3{w_ist}} & pwdata[2:0])) | ev;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			imk_q <= 3'h0;
		end else if (w_imk) begin
			imk_q <= pwdata[2:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(((ist_q & ~({3{w_ist}} & pwdata[2:0])) | ev) & imk_q);
		end
	end

	// derived configuration
	logic bus16_eff;
	assign bus16_eff = cfg_q[`CCR_CFG_BUSW_BIT] & ~ser_s_q[1] & ~init_s_q[1];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_bus_16       <= 1'b0;
			soft_reset_active <= 1'b0;
			pinmux            <= '0;
			access_ctl        <= '0;
		end else begin
			host_bus_16       <= bus16_eff;
			soft_reset_active <= srst_busy;
			pinmux.i2c_en     <= cfg_q[`CCR_CFG_I2C_BIT];
			pinmux.i2c_on_key0 <= cfg_q[`CCR_CFG_I2C_BIT] & cfg_q[`CCR_CFG_KEY_BIT];
			pinmux.key_in_scan <= cfg_q[`CCR_CFG_KEY_BIT] ?
				{4'hf, ~cfg_q[`CCR_CFG_I2C_BIT]} : 5'h00;
			pinmux.key_out_scan <= cfg_q[`CCR_CFG_KEY_BIT] ?
				{4'hf, ~cfg_q[`CCR_CFG_I2C_BIT]} : 5'h00;
			pinmux.spi_en     <= cfg_q[`CCR_CFG_SPI_BIT];
			pinmux.tft_width  <= cfg_q[4:3];
			pinmux.tft_off    <= (cfg_q[4:3] == 2'h3);
			access_ctl.img_fmt      <= mac_q[7:6];
			access_ctl.mask_all_hi  <= (mac_q[7:6] == 2'h2);
			access_ctl.mask_even_hi <= (mac_q[7:6] == 2'h3);
			access_ctl.rd_dir <= lin_s_q[1] ? 2'h0 : mac_q[5:4];
			access_ctl.wr_dir <= lin_s_q[1] ? 2'h0 : mac_q[2:1];
		end
	end

	// stall: masked on cs release when bit 6 set
	logic busy_any;
	assign busy_any = busy_s_q[1] | srst_busy | pll_busy;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_wait_n <= 1'b1;
		end else if (cfg_q[`CCR_CFG_MASKW_BIT] && cs_s_q[1]) begin
			host_wait_n <= 1'b1;
		end else begin
			host_wait_n <= ~busy_any;
		end
	end

	// read mux
	function automatic logic [7:0] rd_val(input logic [9:0] i);
		case (i[2:0])
			3'h0: rd_val = {pll_bit_q, 5'h00, warn_q, 1'b0};
			3'h1: rd_val = {pll_rdy_q, cfg_q[6:1], bus16_eff};
			3'h2: rd_val = mac_q;
			3'h3: rd_val = {5'h00, ist_q};
			3'h4: rd_val = {5'h00, imk_q};
			default: rd_val = 8'h00;
		endcase
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			prdata  <= (psel & ~penable & ~pwrite & mapped) ? {24'h000000, rd_val(idx)} : 32'h0;
		end
	end

	// assertions
	a_srst_self_clear: assert property (@(posedge pclk) disable iff (!presetn)
		srst_start |=> srst_bit_q [*8] ##[1:4] !srst_bit_q)
		else $error("soft reset bit did not self-clear");
	a_pll_bit_read: assert property (@(posedge pclk) disable iff (!presetn)
		pll_start |=> pll_bit_q ##[1:30] (!pll_bit_q && pll_rdy_q))
		else $error("pll bit did not clear with ready");
	a_pll_live_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!pll_done |=> $stable(pll_live_q))
		else $error("pll live changed without reconfigure");
	a_cfg_kept: assert property (@(posedge pclk) disable iff (!presetn)
		(srst_busy && !w_cfg) |=> $stable(cfg_q))
		else $error("config changed during soft reset");
	a_warn_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(warn_s_q[1] && !srst_busy) |=> warn_q)
		else $error("warning flag not set");
	a_wait_mask: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_q[6] && cs_s_q[1]) |=> host_wait_n)
		else $error("stall not released on cs release");
	a_wait_busy: assert property (@(posedge pclk) disable iff (!presetn)
		(!cfg_q[6] && busy_any) |=> !host_wait_n)
		else $error("stall not held while busy");
	a_bus_force: assert property (@(posedge pclk) disable iff (!presetn)
		(ser_s_q[1] || init_s_q[1]) |=> !host_bus_16)
		else $error("bus width not forced to 8");
	a_srr_resv: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && mapped && idx == 10'h000) |=>
		(prdata[6:2] == 5'h00 && prdata[0] == 1'b0))
		else $error("reserved bits read nonzero");
	a_dir_linear: assert property (@(posedge pclk) disable iff (!presetn)
		lin_s_q[1] |=> (access_ctl.wr_dir == 2'h0 && access_ctl.rd_dir == 2'h0))
		else $error("direction not ignored in linear mode");
	a_srst_warn: assert property (@(posedge pclk) disable iff (!presetn)
		srst_busy |=> !warn_q)
		else $error("warning flag not restored by soft reset");
	a_warn_stat: assert property (@(posedge pclk) disable iff (!presetn)
		ev[2] |=> ist_q[2])
		else $error("warning status bit not set");
	a_tft_none: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_q[4:3] == 2'h3) |=> pinmux.tft_off)
		else $error("tft output not disabled");
	a_i2c_key0: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_q[2] && cfg_q[5]) |=> (pinmux.i2c_on_key0 && !pinmux.key_in_scan[0]))
		else $error("key line 0 not given to i2c");
	a_bus_pass: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_q[0] && !ser_s_q[1] && !init_s_q[1]) |=> host_bus_16)
		else $error("bus width not taken from register");
	c_soft_reset: cover property (@(posedge pclk) disable iff (!presetn) srst_done);
	c_pll_switch: cover property (@(posedge pclk) disable iff (!presetn) pll_done);
	c_irq_raise: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
	c_wait_stall: cover property (@(posedge pclk) disable iff (!presetn) $fell(host_wait_n));
	c_dir_linear: cover property (@(posedge pclk) disable iff (!presetn)
		lin_s_q[1] && mac_q[2:1] != 2'h0);
endmodule // ccr_regs

// file: rtl/ccr_consts.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: apb byte addresses are four times the register index
// Notes: definitions only
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH
`define CCR_IDX_SRR        8'h00
`define CCR_IDX_CFG        8'h01
`define CCR_IDX_MAC        8'h02
`define CCR_IDX_IRQ_STAT   8'h03
`define CCR_IDX_IRQ_MASK   8'h04
`define CCR_SRR_PLL_BIT    7
`define CCR_SRR_SRST_BIT   0
`define CCR_CFG_PLLRDY_BIT 7
`define CCR_CFG_MASKW_BIT  6
`define CCR_CFG_KEY_BIT    5
`define CCR_CFG_I2C_BIT    2
`define CCR_CFG_SPI_BIT    1
`define CCR_CFG_BUSW_BIT   0
`define CCR_CFG_RESET      8'h48
`define CCR_MAC_RESET      8'h00
`define CCR_MAC_WMASK      8'hf6
`define CCR_SRST_NS        160
`define CCR_PLL_NS         400
`define CCR_CLK_NS         20
`define CCR_SRST_CYC       ((`CCR_SRST_NS + `CCR_CLK_NS - 1) / `CCR_CLK_NS)
`define CCR_PLL_CYC        ((`CCR_PLL_NS + `CCR_CLK_NS - 1) / `CCR_CLK_NS)
`define CCR_IRQ_PLL        0
`define CCR_IRQ_SRST       1
`define CCR_IRQ_WARN       2
`endif

// file: rtl/ccr_pkg.sv
// Purpose: types shared by the configuration register block
// Assumes: nothing beyond the header
// Notes: widths follow the documented 8-bit registers
package ccr_pkg;
	typedef enum logic [1:0] {
		CCR_IDLE = 2'b00,
		CCR_BUSY = 2'b01,
		CCR_DONE = 2'b11
	} ccr_seq_t;
	typedef struct packed {
		logic       i2c_on_key0;
		logic [4:0] key_in_scan;
		logic [4:0] key_out_scan;
		logic       i2c_en;
		logic       spi_en;
		logic [1:0] tft_width;
		logic       tft_off;
	} ccr_pinmux_t;
	typedef struct packed {
		logic [1:0] img_fmt;
		logic       mask_all_hi;
		logic       mask_even_hi;
		logic [1:0] rd_dir;
		logic [1:0] wr_dir;
	} ccr_access_t;
endpackage

// file: rtl/ccr_seq.sv
// Purpose: timed sequencer for soft reset and pll switch-over
// Assumes: start is a one-cycle pulse on pclk
// Notes: done pulses once when the count runs out
`timescale 1ns/1ps
module ccr_seq #(
	parameter int unsigned CYCLES = 8
) (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// control
	input  wire logic start,
	output logic      busy,
	output logic      done
);
	ccr_pkg::ccr_seq_t state_q;
	logic [15:0]       cnt_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ccr_pkg::CCR_IDLE;
			cnt_q   <= 16'h0000;
		end else begin
			case (state_q)
				ccr_pkg::CCR_IDLE: begin
					if (start) begin
						state_q <= ccr_pkg::CCR_BUSY;
						cnt_q   <= 16'(CYCLES - 1);
					end
				end
				ccr_pkg::CCR_BUSY: begin
					if (cnt_q == 16'h0000) begin
						state_q <= ccr_pkg::CCR_DONE;
					end else begin
						cnt_q <= cnt_q - 16'h0001;
					end
				end
				ccr_pkg::CCR_DONE: state_q <= ccr_pkg::CCR_IDLE;
				default: state_q <= ccr_pkg::CCR_IDLE;
			endcase
		end
	end

	assign busy = (state_q == ccr_pkg::CCR_BUSY);
	assign done = (state_q == ccr_pkg::CCR_DONE);
endmodule // ccr_seq

// file: verif/ccr_host_model.sv
// Purpose: host pin model, one chip-select cycle per go pulse
// Assumes: host cannot stretch its cycle, so it polls the stall line
// Notes: accesses counts finished chip-select cycles
`timescale 1ns/1ps
module ccr_host_model (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// command and pins
	input  wire logic go,
	input  wire logic host_wait_n,
	output logic      host_cs_n,
	output logic [3:0] accesses
);
	logic [1:0] st_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= 2'h0;
			host_cs_n <= 1'b1;
			accesses <= 4'h0;
		end else begin
			case (st_q)
				2'h0: if (go) st_q <= 2'h1;
				2'h1: if (host_wait_n) begin
					host_cs_n <= 1'b0;
					st_q <= 2'h2;
				end
				2'h2: st_q <= 2'h3;
				default: begin
					host_cs_n <= 1'b1;
					accesses <= accesses + 4'h1;
					st_q <= 2'h0;
				end
			endcase
		end
	end
endmodule // ccr_host_model

// file: verif/testbench.sv
// Purpose: self-checking bench for the configuration registers
// Assumes: byte address is four times the register index
// Notes: irq mask polarity is left open, so only its effect is compared
`timescale 1ns/1ps
`include "ccr_consts.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic pready, pslverr, host_cs_n, host_wait_n, soft_reset_active, host_bus_16, irq;
	logic serial_host_sel = 0, init_display = 0, core_busy = 0, warning_event = 0;
	logic canvas_linear = 0, a, e;
	logic [7:0] pll_param_in = 0, pll_param_stage, pll_param_live, d;
	logic [3:0] accesses;
	logic [31:0] r;
	ccr_pkg::ccr_pinmux_t pinmux;
	ccr_pkg::ccr_access_t access_ctl;
	int num_errors = 0, checked = 0;
	always #10 pclk = ~pclk;
	ccr_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .host_cs_n(host_cs_n), .serial_host_sel(serial_host_sel),
		.init_display(init_display), .core_busy(core_busy), .warning_event(warning_event),
		.canvas_linear(canvas_linear), .host_wait_n(host_wait_n),
		.pll_param_stage(pll_param_stage), .pll_param_in(pll_param_in),
		.pll_param_live(pll_param_live), .soft_reset_active(soft_reset_active),
		.host_bus_16(host_bus_16), .pinmux(pinmux), .access_ctl(access_ctl), .irq(irq));
	ccr_host_model host_u (.pclk(pclk), .presetn(presetn), .go(go),
		.host_wait_n(host_wait_n), .host_cs_n(host_cs_n), .accesses(accesses));
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0; penable <= 0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		apb(1, {2'b00, idx, 2'b00}, {24'h0, v});
		// derived outputs are registered twice behind the write
		cyc(2);
	endtask
	task automatic rd(input logic [7:0] idx);
		apb(0, {2'b00, idx, 2'b00}, 32'h0);
		d = r[7:0];
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic pulse_go();
		go <= 1; cyc(1); go <= 0;
	endtask
	task automatic t_reset();
		rd(`CCR_IDX_CFG); `CHK("cfg", 8'h48, d)
		rd(`CCR_IDX_SRR); `CHK("srr", 8'h00, d)
		`CHK("tftw", 2'b01, pinmux.tft_width)
	endtask
	task automatic t_pins();
		for (int i = 0; i < 4; i++) begin
			wr(`CCR_IDX_CFG, 8'h40 | (i << 3));
			`CHK("tftw", i[1:0], pinmux.tft_width)
			`CHK("tftoff", (i == 3), pinmux.tft_off)
		end
		wr(`CCR_IDX_CFG, 8'h66);
		`CHK("i2c", 1'b1, pinmux.i2c_en)
		`CHK("k0", 1'b1, pinmux.i2c_on_key0)
		`CHK("kin", 5'h1e, pinmux.key_in_scan)
		`CHK("kout", 5'h1e, pinmux.key_out_scan)
		`CHK("spi", 1'b1, pinmux.spi_en)
		wr(`CCR_IDX_CFG, 8'h41); cyc(5);
		`CHK("bus16", 1'b1, host_bus_16)
		serial_host_sel <= 1; cyc(5);
		`CHK("bus16s", 1'b0, host_bus_16)
		rd(`CCR_IDX_CFG); `CHK("cfg0", 1'b0, d[0])
		serial_host_sel <= 0; init_display <= 1; cyc(5);
		`CHK("bus16i", 1'b0, host_bus_16)
		init_display <= 0;
	endtask
	task automatic t_mac();
		wr(`CCR_IDX_MAC, 8'hb4);
		`CHK("fmt", 2'b10, access_ctl.img_fmt)
		`CHK("all", 1'b1, access_ctl.mask_all_hi)
		`CHK("rdd", 2'b11, access_ctl.rd_dir)
		`CHK("wrd", 2'b10, access_ctl.wr_dir)
		wr(`CCR_IDX_MAC, 8'hfe);
		rd(`CCR_IDX_MAC); `CHK("mac", 8'hf6, d)
		`CHK("even", 2'b01, {access_ctl.mask_all_hi, access_ctl.mask_even_hi})
		canvas_linear <= 1; cyc(5);
		`CHK("lin", 4'h0, {access_ctl.rd_dir, access_ctl.wr_dir})
		canvas_linear <= 0;
	endtask
	task automatic t_pll();
		pll_param_in <= 8'h5a; cyc(3);
		`CHK("live0", 8'h00, pll_param_live)
		wr(`CCR_IDX_SRR, 8'h80);
		rd(`CCR_IDX_SRR); `CHK("pllb", 1'b1, d[7])
		for (int i = 0; i < 40 && d[7] !== 1'b0; i++) rd(`CCR_IDX_SRR);
		`CHK("pllc", 1'b0, d[7])
		pll_param_in <= 8'h33; cyc(3);
		`CHK("live", 8'h5a, pll_param_live)
		`CHK("stage", 8'h33, pll_param_stage)
		rd(`CCR_IDX_CFG); `CHK("rdy", 1'b1, d[7])
	endtask
	task automatic t_srst();
		warning_event <= 1; cyc(4); warning_event <= 0; cyc(4);
		rd(`CCR_IDX_SRR); `CHK("warn", 1'b1, d[1])
		wr(`CCR_IDX_CFG, 8'h54);
		wr(`CCR_IDX_SRR, 8'h7f); cyc(1);
		`CHK("sra", 1'b1, soft_reset_active)
		rd(`CCR_IDX_SRR); `CHK("rsv", 6'h00, {d[6:2], d[0]})
		for (int i = 0; i < 20 && soft_reset_active !== 1'b0; i++) cyc(1);
		`CHK("srd", 1'b0, soft_reset_active)
		rd(`CCR_IDX_SRR); `CHK("warnc", 1'b0, d[1])
		rd(`CCR_IDX_CFG); `CHK("keep", 7'h54, d[6:0])
	endtask
	task automatic t_irq();
		rd(`CCR_IDX_IRQ_STAT); `CHK("stat", 3'h7, d[2:0])
		wr(`CCR_IDX_IRQ_MASK, 8'h00); cyc(2); a = irq;
		wr(`CCR_IDX_IRQ_MASK, 8'h07); cyc(2);
		`CHK("mask", 1'b1, a ^ irq)
		wr(`CCR_IDX_IRQ_STAT, 8'h07); cyc(2);
		rd(`CCR_IDX_IRQ_STAT); `CHK("w1c", 3'h0, d[2:0])
		`CHK("irq0", 1'b0, irq)
		apb(1, 12'h014, 32'hff); `CHK("unm", 1'b1, e)
		apb(0, 12'h001, 32'h0); `CHK("unal", 33'h100000000, {e, r})
	endtask
	task automatic t_stall();
		wr(`CCR_IDX_CFG, 8'h14);
		// stall reaches the pin three cycles after core_busy
		core_busy <= 1; cyc(4); pulse_go(); cyc(12);
		`CHK("stall", 1'b0, host_wait_n)
		`CHK("held", 4'h0, accesses)
		core_busy <= 0; cyc(12);
		`CHK("go1", 4'h1, accesses)
		wr(`CCR_IDX_CFG, 8'h54);
		pulse_go(); core_busy <= 1; cyc(12);
		`CHK("go2", 4'h2, accesses)
		`CHK("msk", 1'b1, host_wait_n)
		core_busy <= 0;
	endtask
	task automatic tally_and_finish();
		if (num_errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		cyc(5);
		presetn <= 1;
		t_reset(); t_pins(); t_mac(); t_pll(); t_srst(); t_irq(); t_stall();
		tally_and_finish();
	end
	initial begin
		#200000;
		num_errors++;
		tally_and_finish();
	end
endmodule // testbench
